// ### rtl/tss_pkg.sv
// Purpose: shared constants, types and helpers of the transmit sequencer
// Assumes: 50 MHz system clock
// Notes: all timing counts derive from the clock rate below
package tss_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int US_PER_MS = 1_000;
  localparam int CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int XO_SETTLE_US = 400;
  localparam int TUNE_SETTLE_US = 370;
  localparam int XO_SETTLE_CYC = XO_SETTLE_US * CYC_PER_US;
  localparam int TUNE_SETTLE_CYC = TUNE_SETTLE_US * CYC_PER_US;
  localparam int MS_CYC_DEF = US_PER_MS * CYC_PER_US;

  // ****************************************************************
  // configuration ranges and defaults
  // ****************************************************************
  localparam int NBTN = 7;
  localparam logic [22:0] PERIOD_MIN_MS = 23'h0007d0;
  localparam logic [22:0] PERIOD_MAX_MS = 23'h753db8;
  localparam logic [22:0] PERIOD_DEF_MS = 23'h0003e8;
  localparam logic [3:0] STUDY_DEF_S = 4'h5;
  localparam logic [13:0] MS_PER_S = 14'h03e8;
  localparam logic signed [4:0] TX_PWR_MIN = 5'sh16;
  localparam logic signed [4:0] TX_PWR_MAX = 5'sh0d;
  localparam logic signed [4:0] STUDY_PWR_MAX = 5'sh0e;
  localparam logic signed [4:0] STUDY_PWR_DEF = 5'sh1a;
  localparam logic [3:0] RAMP_SEL_NONE = 4'h0;
  localparam logic [3:0] RAMP_SEL_MAX = 4'hb;
  localparam logic [7:0] LVL_FULL = 8'hff;
  localparam logic [3:0] SYM_1920_BASE = 4'h3;
  localparam logic [3:0] SYM_1527 = 4'h4;
  localparam logic [3:0] SYM_2262 = 4'h8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_XO = 2'b01,
    ST_TUNE = 2'b10,
    ST_TX = 2'b11
  } tss_state_t;

  typedef enum logic [1:0] {
    FMT_1920 = 2'b00,
    FMT_1527 = 2'b01,
    FMT_2262 = 2'b10
  } tss_fmt_t;

  typedef enum logic [1:0] {
    BM_NORMAL = 2'b00,
    BM_MATRIX = 2'b01,
    BM_TOGGLE = 2'b10,
    BM_PWM = 2'b11
  } tss_bmode_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic signed [4:0] clamp_pwr(
    input logic signed [4:0] v, input logic signed [4:0] hi);
    if (v < TX_PWR_MIN)
      return TX_PWR_MIN;
    else if (v > hi)
      return hi;
    return v;
  endfunction

  function automatic logic [22:0] clamp_period(input logic [22:0] v);
    if (v < PERIOD_MIN_MS)
      return PERIOD_MIN_MS;
    else if (v > PERIOD_MAX_MS)
      return PERIOD_MAX_MS;
    return v;
  endfunction

endpackage

// ### rtl/tss_tmr_if.sv
// Purpose: load/expire handshake between sequencer and wait timer
// Assumes: single clock domain
// Notes: expired is a one-cycle pulse
`timescale 1ns/1ps
interface tss_tmr_if;
  logic load;
  logic [31:0] value;
  logic expired;
  modport ctl (output load, output value, input expired);
  modport tmr (input load, input value, output expired);
endinterface

// ### rtl/tss_wait_timer.sv
// Purpose: down counter for crystal and synthesizer settle waits
// Assumes: value of at least one
// Notes: expired pulses value+1 cycles after load
`timescale 1ns/1ps
module tss_wait_timer
  import tss_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  tss_tmr_if.tmr t // load and expire
);

  logic [31:0] cnt_q;
  logic exp_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      cnt_q <= 32'h0;
    else if (t.load)
      cnt_q <= t.value;
    else if (cnt_q != 32'h0)
      cnt_q <= cnt_q - 32'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      exp_q <= 1'b0;
    else
      exp_q <= !t.load && cnt_q == 32'h1;
  end

  assign t.expired = exp_q;

endmodule

// ### rtl/tss_pa_ramp.sv
// Purpose: power amplifier ramp up and down envelope
// Assumes: selection 0 = instant, n = 2^(n-1) us
// Notes: down ramp walks the same counter back, so it takes as long
`timescale 1ns/1ps
module tss_pa_ramp
  import tss_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic on_i, // amplifier requested on
  input wire logic [3:0] sel_i, // ramp time selection
  output logic [7:0] level_o, // envelope level, registered
  output logic up_done_o, // at full level
  output logic down_done_o // fully off
);

  logic [5:0] pre_q;
  logic tick;
  logic [3:0] sel;
  logic [10:0] span;
  logic [10:0] cnt_q;
  logic [18:0] scaled;
  logic [7:0] level_d;
  logic [7:0] level_q;

  assign sel = (sel_i > RAMP_SEL_MAX) ? RAMP_SEL_MAX : sel_i;
  assign span = (sel == RAMP_SEL_NONE) ? 11'h000 :
    11'(11'h001 << (sel - 4'h1)); // RL11
  assign tick = pre_q == 6'(CYC_PER_US - 1);
  assign scaled = {cnt_q, 8'h00} >> (sel - 4'h1);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || tick)
      pre_q <= 6'h00;
    else
      pre_q <= pre_q + 6'h01;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || span == 11'h000)
      cnt_q <= 11'h000;
    else if (on_i && cnt_q > span)
      cnt_q <= span;
    else if (tick && on_i && cnt_q < span)
      cnt_q <= cnt_q + 11'h001;
    else if (tick && !on_i && cnt_q != 11'h000)
      cnt_q <= cnt_q - 11'h001; // RL13
  end

  always_comb
  begin
    level_d = 8'h00;
    if (span == 11'h000)
      level_d = on_i ? LVL_FULL : 8'h00; // RL12
    else if (scaled > 19'(LVL_FULL))
      level_d = LVL_FULL;
    else
      level_d = scaled[7:0];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      level_q <= 8'h00;
    else
      level_q <= level_d;
  end

  assign level_o = level_q;
  assign up_done_o = on_i && (span == 11'h000 || cnt_q == span);
  assign down_done_o = !on_i && cnt_q == 11'h000;

  // ****************************************************************
  // checks
  // ****************************************************************
  instant_ramp_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    on_i && sel == RAMP_SEL_NONE |=> level_o == LVL_FULL) // RL12
    else $error("instant ramp did not reach full level");
  full_at_top_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    up_done_o && span != 11'h000 |=> level_o == LVL_FULL) // RL11
    else $error("ramp end without full level");
  ramp_down_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !on_i && tick && cnt_q != 11'h000 ##1 !on_i |-> cnt_q < $past(cnt_q)) // RL13
    else $error("ramp down did not step");

endmodule

// ### rtl/tss_sequencer.sv
// Purpose: sleep, crystal start, tune, transmit sequencer of a transmitter
// Assumes: 50 MHz clock, packet encoder answers pkt_done_i on this clock
// Notes: button and ready pins pass a three-stage synchroniser
// Notes on behaviour
// [RL1] only four states: sleep, crystal start-up, tune and transmit
// [RL2] idle in sleep; a press walks start-up, tune, then transmit
// [RL3] after the last packet the sequencer returns to sleep
// [RL4] periodic mode wakes from sleep each period for the same walk
// [RL5] wake period loaded only while periodic mode on, 2 s to 7683.512 s; reset value here is 1 s, kept while period input is 0
// [RL6] in sleep crystal, synthesizer and amplifier are all off
// [RL7] crystal start-up waits the settle time, typically 400 us
// [RL8] tune waits synthesizer settle, typically 370 us
// [RL9] amplifier turns on only after tune has finished
// [RL10] packets carry format, button mode and pressed buttons
// [RL11] ramp time selectable: 0, 1, 2, 4 ... 1024 us
// [RL12] ramp selection zero reaches full power at once
// [RL13] ramp down lasts as long as ramp up
// [RL14] software should keep ramp time at most half a symbol time
// [RL15] normal output power held within -10 to +13 dBm
// [RL16] study has an enable and works only in 1920 and 1527 formats
// [RL17] study packets start a set 1 to 15 s after pressing, default 5
// [RL18] study button picked among the enabled buttons
// [RL19] study packets use their own power, -10 to +14 dBm, default -6
// [RL20] symbols per bit: 1920 three to six, 1527 four, 2262 eight
// [RL21] format 2262 forces normal button mode
// [RL22] 1 to 256 packets per press (minimum) and per periodic wake
// [RL23] study button released early gives an ordinary press
// [RL24] state waits end on ready indication or fixed cycle count
`timescale 1ns/1ps
module tss_sequencer
  import tss_pkg::*;
#(
  parameter int XO_CYC = XO_SETTLE_CYC, // crystal settle cycles
  parameter int TUNE_CYC = TUNE_SETTLE_CYC, // synthesizer settle cycles
  parameter int MS_CYC = MS_CYC_DEF // cycles per millisecond
)
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic [NBTN-1:0] button_i, // push buttons, pin level
  input wire logic xo_ready_i, // crystal stable indication, pin
  input wire logic synth_lock_i, // synthesizer locked indication, pin
  input wire logic [NBTN-1:0] btn_enable_i, // buttons in use
  input wire logic [1:0] format_i, // encoding format
  input wire logic [1:0] button_mode_i, // button mode
  input wire logic [1:0] bit_format_i, // 1920 bit format, 3+n sym
  input wire logic [7:0] pkt_count_i, // packets minus one
  input wire logic periodic_en_i, // periodic transmission on
  input wire logic [22:0] period_ms_i, // wake period in ms, 0 keeps
  input wire logic [3:0] ramp_sel_i, // ramp time selection
  input wire logic signed [4:0] tx_power_i, // normal power, dBm
  input wire logic study_en_i, // id study on
  input wire logic [3:0] study_delay_i, // study delay s, 0 keeps
  input wire logic [2:0] study_btn_i, // study button index
  input wire logic signed [4:0] study_power_i, // study power, dBm
  input wire logic pkt_done_i, // encoder finished a packet
  output logic [1:0] state_o, // working state
  output logic xo_en_o, // crystal oscillator enable
  output logic synth_en_o, // synthesizer enable
  output logic pa_en_o, // amplifier enable
  output logic [7:0] pa_level_o, // amplifier envelope
  output logic signed [4:0] pa_power_o, // amplifier power, dBm
  output logic pkt_start_o, // start one packet, pulse
  output logic pkt_study_o, // packet is a study packet
  output logic [NBTN-1:0] pkt_btn_o, // buttons encoded
  output logic [1:0] pkt_fmt_o, // format for encoder
  output logic [1:0] pkt_mode_o, // button mode for encoder
  output logic [3:0] pkt_sym_o // symbols per bit
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  tss_state_t state_q;
  tss_fmt_t fmt;
  tss_tmr_if tmr ();
  logic [NBTN+1:0] raw, s1_q, s2_q, s3_q, in_q;
  logic [NBTN-1:0] btn_now, study_mask, btn_lat_q;
  logic xo_ok, lock_ok;
  logic [31:0] ms_pre_q;
  logic ms_tick;
  logic [22:0] period_q, per_cnt_q;
  logic per_wake;
  logic [3:0] stu_delay_q;
  logic signed [4:0] stu_pwr_q;
  logic [13:0] stu_cnt_q, stu_target;
  logic study_ok, stu_hold, stu_arm_q, stu_wake, stu_cancel, btn_wake;
  logic load_q, study_q, per_run_q;
  logic [31:0] value_q;
  logic pa_on_q, fin_q, busy_q, start_q, more;
  logic [8:0] sent_q, target;
  logic up_done, down_done;
  logic [7:0] level;
  logic xo_en_q, synth_en_q, pa_en_q, pkt_study_q;
  logic signed [4:0] pa_power_q;
  logic [NBTN-1:0] pkt_btn_q;
  logic [1:0] pkt_fmt_q, pkt_mode_q;
  logic [3:0] pkt_sym_q;

  function automatic tss_fmt_t fmt_norm(input logic [1:0] f);
    unique case (f)
      2'b00: return FMT_1920;
      2'b10: return FMT_2262;
      default: return FMT_1527;
    endcase
  endfunction

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  assign raw = {synth_lock_i, xo_ready_i, button_i};

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & in_q);
    end
  end

  assign btn_now = in_q[NBTN-1:0] & btn_enable_i;
  assign xo_ok = in_q[NBTN];
  assign lock_ok = in_q[NBTN+1];
  assign fmt = fmt_norm(format_i);

  // ****************************************************************
  // millisecond tick and periodic wake
  // ****************************************************************
  assign ms_tick = ms_pre_q == 32'(MS_CYC - 1);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || ms_tick)
      ms_pre_q <= 32'h0;
    else
      ms_pre_q <= ms_pre_q + 32'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      period_q <= PERIOD_DEF_MS;
    else if (periodic_en_i && period_ms_i != 23'h0)
      period_q <= clamp_period(period_ms_i); // RL5
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !periodic_en_i || state_q != ST_SLEEP)
      per_cnt_q <= 23'h0;
    else if (ms_tick && per_cnt_q < period_q)
      per_cnt_q <= per_cnt_q + 23'h1;
  end

  assign per_wake = periodic_en_i && state_q == ST_SLEEP &&
    per_cnt_q >= period_q; // RL4

  // ****************************************************************
  // id study trigger
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      stu_delay_q <= STUDY_DEF_S;
      stu_pwr_q <= STUDY_PWR_DEF;
    end
    else if (study_en_i)
    begin
      if (study_delay_i != 4'h0)
        stu_delay_q <= study_delay_i; // RL17
      stu_pwr_q <= clamp_pwr(study_power_i, STUDY_PWR_MAX); // RL19
    end
  end

  assign study_ok = study_en_i && fmt != FMT_2262; // RL16
  assign study_mask = NBTN'(7'h01 << study_btn_i) & btn_enable_i; // RL18
  assign stu_hold = study_ok && study_mask != '0 && btn_now == study_mask;
  assign stu_target = 14'({10'h000, stu_delay_q} * MS_PER_S);
  assign stu_wake = stu_hold && stu_cnt_q == stu_target; // RL17
  assign stu_cancel = stu_arm_q && btn_now == '0; // RL23
  assign btn_wake = btn_now != '0 && !stu_hold;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || state_q != ST_SLEEP || !stu_hold)
      stu_cnt_q <= 14'h0;
    else if (ms_tick && stu_cnt_q != stu_target)
      stu_cnt_q <= stu_cnt_q + 14'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || state_q != ST_SLEEP || stu_wake || btn_wake)
      stu_arm_q <= 1'b0;
    else if (stu_hold)
      stu_arm_q <= 1'b1;
  end

  // ****************************************************************
  // working state sequence
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_SLEEP;
      load_q <= 1'b0;
      value_q <= 32'h0;
      study_q <= 1'b0;
      per_run_q <= 1'b0;
      btn_lat_q <= '0;
    end
    else
    begin
      load_q <= 1'b0;
      unique case (state_q) // RL1
        ST_SLEEP:
          if (stu_wake || stu_cancel || btn_wake || per_wake)
          begin
            state_q <= ST_XO; // RL2
            load_q <= 1'b1;
            value_q <= 32'(XO_CYC); // RL7
            study_q <= stu_wake;
            per_run_q <= !(stu_wake || stu_cancel || btn_wake); // RL4
            btn_lat_q <= (stu_wake || stu_cancel) ? study_mask : btn_now;
          end
        ST_XO:
          if (xo_ok || tmr.expired)
          begin
            state_q <= ST_TUNE; // RL24
            load_q <= 1'b1;
            value_q <= 32'(TUNE_CYC); // RL8
          end
        ST_TUNE:
          if (lock_ok || tmr.expired)
            state_q <= ST_TX; // RL24
        ST_TX:
          if (fin_q && down_done)
            state_q <= ST_SLEEP; // RL3
      endcase
    end
  end

  assign tmr.load = load_q;
  assign tmr.value = value_q;

  tss_wait_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .t(tmr)
  );

  // ****************************************************************
  // transmit: ramp, packets, ramp down
  // ****************************************************************
  assign target = {1'b0, pkt_count_i} + 9'h001;
  assign more = sent_q < target ||
    (!per_run_q && !study_q && btn_now != '0); // RL22

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || state_q != ST_TX)
    begin
      pa_on_q <= 1'b0;
      fin_q <= 1'b0;
      sent_q <= 9'h000;
      busy_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (!fin_q)
        pa_on_q <= 1'b1; // RL9
      if (busy_q && pkt_done_i)
      begin
        busy_q <= 1'b0;
        sent_q <= (sent_q == 9'h1ff) ? sent_q : sent_q + 9'h001;
      end
      else if (pa_on_q && up_done && !busy_q && !start_q)
      begin
        if (more)
        begin
          start_q <= 1'b1; // RL10
          busy_q <= 1'b1;
        end
        else
        begin
          fin_q <= 1'b1;
          pa_on_q <= 1'b0;
        end
      end
    end
  end

  tss_pa_ramp u_ramp (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .on_i(pa_on_q),
    .sel_i(ramp_sel_i),
    .level_o(level),
    .up_done_o(up_done),
    .down_done_o(down_done)
  );

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      xo_en_q <= 1'b0;
      synth_en_q <= 1'b0;
      pa_en_q <= 1'b0;
      pa_power_q <= 5'sh00;
    end
    else
    begin
      xo_en_q <= state_q != ST_SLEEP; // RL6
      synth_en_q <= state_q == ST_TUNE || state_q == ST_TX;
      pa_en_q <= pa_on_q || level != 8'h00;
      pa_power_q <= study_q ? stu_pwr_q :
        clamp_pwr(tx_power_i, TX_PWR_MAX); // RL15
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pkt_study_q <= 1'b0;
      pkt_btn_q <= '0;
      pkt_fmt_q <= FMT_1527;
      pkt_mode_q <= BM_NORMAL;
      pkt_sym_q <= SYM_1527;
    end
    else
    begin
      pkt_study_q <= study_q;
      pkt_btn_q <= btn_lat_q; // RL10
      pkt_fmt_q <= fmt;
      pkt_mode_q <= (fmt == FMT_2262) ? BM_NORMAL : button_mode_i; // RL21
      unique case (fmt) // RL20
        FMT_1920: pkt_sym_q <= SYM_1920_BASE + {2'b00, bit_format_i};
        FMT_1527: pkt_sym_q <= SYM_1527;
        FMT_2262: pkt_sym_q <= SYM_2262;
      endcase
    end
  end

  assign state_o = state_q;
  assign xo_en_o = xo_en_q;
  assign synth_en_o = synth_en_q;
  assign pa_en_o = pa_en_q;
  assign pa_level_o = level;
  assign pa_power_o = pa_power_q;
  assign pkt_start_o = start_q;
  assign pkt_study_o = pkt_study_q;
  assign pkt_btn_o = pkt_btn_q;
  assign pkt_fmt_o = pkt_fmt_q;
  assign pkt_mode_o = pkt_mode_q;
  assign pkt_sym_o = pkt_sym_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sleep_quiet_a: assert property (state_q == ST_SLEEP &&
    $past(state_q) == ST_SLEEP |-> !xo_en_o && !synth_en_o) // RL6
    else $error("block powered in sleep");
  state_order_a: assert property (state_q != $past(state_q) |->
    state_q == tss_state_t'($past(state_q) + 2'b01)) // RL2
    else $error("state skipped");
  pa_after_tune_a: assert property (pa_on_q |-> state_q == ST_TX) // RL9
    else $error("amplifier on before tune done");
  xo_leave_a: assert property (state_q == ST_XO ##1 state_q == ST_TUNE
    |-> $past(xo_ok || tmr.expired)) // RL7
    else $error("crystal wait cut short");
  tune_leave_a: assert property (state_q == ST_TUNE ##1 state_q == ST_TX
    |-> $past(lock_ok || tmr.expired)) // RL8
    else $error("tune wait cut short");
  back_sleep_a: assert property (state_q == ST_TX && fin_q && down_done
    |=> state_q == ST_SLEEP) // RL3
    else $error("no return to sleep");
  study_fmt_a: assert property (pkt_study_o && state_q == ST_TX
    |-> pkt_fmt_o != FMT_2262) // RL16
    else $error("study in 2262 format");
  mode_2262_a: assert property (pkt_fmt_o == FMT_2262
    |-> pkt_mode_o == BM_NORMAL) // RL21
    else $error("2262 with non-normal mode");
  power_range_a: assert property (pa_power_o >= TX_PWR_MIN &&
    pa_power_o <= STUDY_PWR_MAX) // RL19
    else $error("power out of range");
  pkt_min_a: assert property (state_q == ST_TX && fin_q
    |-> sent_q >= target) // RL22
    else $error("too few packets sent");

  wake_btn_c: cover property (state_q == ST_SLEEP ##1 state_q == ST_XO);
  wake_per_c: cover property (per_wake ##1 state_q == ST_XO);
  study_c: cover property (stu_wake ##1 study_q);
  full_walk_c: cover property (state_q == ST_TX ##1 state_q == ST_SLEEP);

endmodule

// ### tb/tss_encoder_model.sv
// Purpose: stand-in for the packet encoder and air link
// Assumes: one packet start outstanding at a time
// Notes: answers each start dly_i+2 cycles later, so fast or slow
`timescale 1ns/1ps
module tss_encoder_model
(
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic start_i, // packet start pulse
  input wire logic [3:0] dly_i, // answer delay in cycles
  output logic done_o // packet finished pulse
);
  logic [4:0] cnt_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 5'h00;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= (cnt_q == 5'h01);
      if (start_i)
        cnt_q <= {1'b0, dly_i} + 5'h01;
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// ### tb/tss_sequencer_test.sv
// Purpose: self-checking bench of the transmit sequencer
// Assumes: shortened settle and millisecond counts
// Notes: prints only mismatches and the verdict
`timescale 1ns/1ps
module tss_sequencer_test;
  import tss_pkg::*;
  logic sys_clk_i, rst_i, xo_rdy, lock, done, per_en, s_en, start, study;
  logic xo_en, synth_en, pa_en, stdy_s;
  logic [6:0] btn, ben, pbtn;
  logic [1:0] fmt, mode, state_o, md_o, bf, pfmt;
  logic [2:0] s_btn;
  logic [7:0] cnt, lvl, lvl_s;
  logic [22:0] per_ms;
  logic [3:0] sym, ramp, dly;
  logic signed [4:0] txp, pwr, pwr_s;
  int bad_count = 0;
  int n_tests = 0;
  int n_pkt;
  int n_up, n_dn;
  tss_sequencer #(.XO_CYC(20), .TUNE_CYC(20), .MS_CYC(5)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .button_i(btn),
    .xo_ready_i(xo_rdy), .synth_lock_i(lock), .btn_enable_i(ben),
    .format_i(fmt), .button_mode_i(mode), .bit_format_i(bf),
    .pkt_count_i(cnt), .periodic_en_i(per_en), .period_ms_i(per_ms),
    .ramp_sel_i(ramp), .tx_power_i(txp), .study_en_i(s_en),
    .study_delay_i(4'h1), .study_btn_i(s_btn), .study_power_i(5'sh02),
    .pkt_done_i(done), .state_o(state_o), .xo_en_o(xo_en),
    .synth_en_o(synth_en), .pa_en_o(pa_en), .pa_level_o(lvl),
    .pa_power_o(pwr), .pkt_start_o(start), .pkt_study_o(study),
    .pkt_btn_o(pbtn), .pkt_fmt_o(pfmt), .pkt_mode_o(md_o),
    .pkt_sym_o(sym));
  tss_encoder_model u_enc (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .start_i(start), .dly_i(dly), .done_o(done));
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // envelope cycles between off and full, before and after the first packet
  always @(posedge sys_clk_i)
  begin
    if (lvl != 8'h00 && lvl != 8'hff && n_pkt == 0)
      n_up <= n_up + 1;
    else if (lvl != 8'h00 && lvl != 8'hff)
      n_dn <= n_dn + 1;
    if (start === 1'b1)
    begin
      n_pkt <= n_pkt + 1;
      lvl_s <= lvl;
      pwr_s <= pwr;
      stdy_s <= study;
    end
  end
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (e !== g)
    begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wait_st(input logic [1:0] s, input int max);
    int i;
    i = 0;
    while (state_o !== s && i < max)
    begin
      tick();
      i++;
    end
    chk("state", {30'h0, s}, {30'h0, state_o});
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_walk();
    n_pkt = 0;
    btn = 7'h01;
    wait_st(2'h1, 10);
    tick();
    chk("xo_en", 1, {31'h0, xo_en});
    btn = 7'h00;
    wait_st(2'h2, 40);
    chk("pa_en", 0, {31'h0, pa_en});
    wait_st(2'h3, 40);
    wait_st(2'h0, 2000);
    chk("packets", 3, n_pkt);
    chk("level", 32'hff, {24'h0, lvl_s});
    chk("power", 32'h16, {27'h0, pwr_s});
    tick();
    chk("sleep_en", 0, {29'h0, xo_en, synth_en, pa_en});
  endtask
  task automatic t_fmt();
    logic [3:0] es [3] = '{4'h5, 4'h4, 4'h8};
    for (int f = 0; f < 3; f++)
    begin
      fmt = f[1:0];
      repeat (3) tick();
      chk("sym", {28'h0, es[f]}, {28'h0, sym});
      chk("mode", (f == 2) ? 0 : 3, {30'h0, md_o});
      chk("fmt", f, {30'h0, pfmt});
    end
  endtask
  task automatic t_per();
    n_pkt = 0;
    dly = 4'h1;
    cnt = 8'h01;
    {xo_rdy, lock, per_en} = 3'b111;
    wait_st(2'h1, 10500);
    wait_st(2'h0, 2000);
    chk("packets", 2, n_pkt);
    {xo_rdy, lock, per_en} = 3'b000;
  endtask
  task automatic t_ramp();
    n_pkt = 0;
    n_up = 0;
    n_dn = 0;
    cnt = 8'h00;
    ramp = 4'h3;
    ben = 7'h7b;
    btn = 7'h06;
    wait_st(2'h1, 10);
    btn = 7'h00;
    wait_st(2'h3, 100);
    wait_st(2'h0, 2000);
    chk("ramp_up", 3 * CYC_PER_US, n_up);
    chk("ramp_dn", 3 * CYC_PER_US, n_dn);
    chk("btn", 32'h02, {25'h0, pbtn});
    ramp = 4'h0;
    ben = 7'h7f;
  endtask
  task automatic t_study();
    cnt = 8'h00;
    fmt = 2'h1;
    s_en = 1'b1;
    s_btn = 3'h2;
    btn = 7'h04;
    repeat (100) tick();
    btn = 7'h00;
    wait_st(2'h1, 10);
    wait_st(2'h0, 500);
    chk("cancel", 0, {31'h0, stdy_s});
    chk("cbtn", 32'h04, {25'h0, pbtn});
    btn = 7'h04;
    repeat (4000) tick();
    chk("early", 0, {30'h0, state_o});
    wait_st(2'h1, 1500);
    btn = 7'h00;
    wait_st(2'h0, 2000);
    chk("study", 1, {31'h0, stdy_s});
    chk("spower", 2, {27'h0, pwr_s});
    chk("sbtn", 32'h04, {25'h0, pbtn});
  endtask
  initial
  begin
    {rst_i, xo_rdy, lock, per_en, s_en} = 5'b10000;
    {btn, fmt, mode, cnt, dly, txp} = {7'h0, 2'h0, 2'h3, 8'h02, 4'h6, 5'sh14};
    {ben, bf, s_btn} = {7'h7f, 2'h2, 3'h0};
    per_ms = 23'h0007d0;
    ramp = 4'h0;
    repeat (8) tick();
    chk("rst_state", 0, {30'h0, state_o});
    rst_i = 1'b0;
    repeat (4) tick();
    t_walk();
    t_fmt();
    t_per();
    t_ramp();
    t_study();
    test_done();
  end
  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    bad_count++;
    test_done();
  end
endmodule
